/* include/sgb_defines.svh */
`ifndef SGB_DEFINES_SVH
`define SGB_DEFINES_SVH

// Avalon byte addresses of the register map
`define SGB_ADDR_W        8
`define SGB_OFF_CTRL      8'h00
`define SGB_OFF_BIAS      8'h04
`define SGB_OFF_STATUS    8'h08
`define SGB_OFF_CMD       8'h0C
`define SGB_OFF_GAIN      8'h40
`define SGB_OFF_GAIN_END  8'h90

// Control word fields
`define SGB_CTRL_BANK     0
`define SGB_CTRL_MODE_LO  4
`define SGB_CTRL_MODE_HI  7
`define SGB_CTRL_GSEL_EN  8
`define SGB_CTRL_TUNE_REQ 9

// Command word fields (write one to act)
`define SGB_CMD_STORE     0

// Status word fields
`define SGB_ST_GRP_LO     0
`define SGB_ST_GRP_HI     1
`define SGB_ST_TUNE_ON    4
`define SGB_ST_SERVO      5

// Sizes and limits
`define SGB_NGRP          4
`define SGB_NVAL          5
`define SGB_NENT          20
`define SGB_GAIN_W        16
`define SGB_BIAS_W        8
`define SGB_MODE_W        4
`define SGB_BIAS_MAX      8'sh64
`define SGB_BIAS_MIN      -8'sh64
`define SGB_BIAS_RST      8'h00
`define SGB_GAIN_RST      16'h0000

`endif

/* include/sgb_pkg.sv */
package sgb_pkg;
  typedef logic [15:0]        sgb_gain_t;
  typedef logic signed [7:0]  sgb_bias_t;
  typedef logic [1:0]         sgb_grp_t;
  typedef logic [3:0]         sgb_mode_t;
  typedef enum logic [0:0] {
    SGB_IDLE = 1'b0,
    SGB_ACK  = 1'b1
  } sgb_bus_t;
endpackage

/* rtl/sgb_rst_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module sgb_rst_sync (
  input  wire logic clk,
  input  wire logic resetn,
  output var  logic rst_n_sync
);
  logic meta_q;

  // Two stages, asserted at once, released in step with clk
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      meta_q     <= 1'b0;
      rst_n_sync <= 1'b0;
    end else begin
      meta_q     <= 1'b1;
      rst_n_sync <= meta_q;
    end
  end
endmodule
`default_nettype wire

/* rtl/sgb_gain_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sgb_defines.svh"
module sgb_gain_bank (
  input  wire logic                 clk,
  input  wire logic                 resetn,
  input  wire logic [7:0]           avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output var  logic [31:0]          avs_readdata,
  output var  logic                 avs_waitrequest,
  input  wire logic                 gain_group_sel,
  input  wire logic                 servo_on,
  input  wire logic                 tune_valid,
  input  wire sgb_pkg::sgb_gain_t   tune_spd_kp,
  input  wire sgb_pkg::sgb_gain_t   tune_spd_ki,
  input  wire sgb_pkg::sgb_gain_t   tune_pos_kp,
  input  wire sgb_pkg::sgb_gain_t   tune_trq_flt,
  input  wire sgb_pkg::sgb_gain_t   tune_spd_flt,
  output var  sgb_pkg::sgb_gain_t   act_spd_kp,
  output var  sgb_pkg::sgb_gain_t   act_spd_ki,
  output var  sgb_pkg::sgb_gain_t   act_pos_kp,
  output var  sgb_pkg::sgb_gain_t   act_trq_flt,
  output var  sgb_pkg::sgb_gain_t   act_spd_flt,
  output var  sgb_pkg::sgb_grp_t    act_group,
  output var  sgb_pkg::sgb_mode_t   gain_switch_mode,
  output var  logic                 online_tune_en,
  output var  sgb_pkg::sgb_bias_t   torque_start,
  output var  logic                 torque_start_vld
);
  import sgb_pkg::*;

  logic        rst_n;
  sgb_bus_t    bus_q;
  sgb_gain_t   mem_q [`SGB_NENT];
  logic        bank_q;
  sgb_mode_t   mode_q;
  logic        gsel_en_q;
  logic        tune_req_q;
  sgb_bias_t   bias_q;
  logic        servo_q;
  sgb_grp_t    sel_d;
  logic        wr_ok;
  logic        gain_hit;
  logic [4:0]  gain_idx;
  logic [7:0]  gain_off;
  logic [31:0] rd_d;
  logic        store_d;
  sgb_bias_t   wbias;

  sgb_rst_sync u_rst (
    .clk        (clk),
    .resetn     (resetn),
    .rst_n_sync (rst_n)
  );

  // Write lands on the edge where waitrequest is seen low
  assign wr_ok    = (bus_q == SGB_ACK) && avs_write;
  assign gain_hit = (avs_address >= `SGB_OFF_GAIN) && (avs_address < `SGB_OFF_GAIN_END);
  assign gain_off = avs_address - `SGB_OFF_GAIN;
  assign gain_idx = gain_off[6:2];
  assign store_d  = wr_ok && (avs_address == `SGB_OFF_CMD) && avs_byteenable[0]
                    && avs_writedata[`SGB_CMD_STORE];
  assign wbias    = avs_writedata[7:0];

  // Bank digit is the high bit, gated select input the low bit
  always_comb begin
    sel_d = {bank_q, gsel_en_q & gain_group_sel};
  end

  // Byte-lane merge for 16-bit fields
  function automatic sgb_gain_t merge16(input sgb_gain_t old, input logic [31:0] d,
                                        input logic [3:0] be);
    merge16 = {be[1] ? d[15:8] : old[15:8], be[0] ? d[7:0] : old[7:0]};
  endfunction

  // One-cycle wait state: request seen, then answered
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_q           <= SGB_IDLE;
      avs_waitrequest <= 1'b1;
    end else if (bus_q == SGB_IDLE) begin
      if (avs_read || avs_write) begin
        bus_q           <= SGB_ACK;
        avs_waitrequest <= 1'b0;
      end
    end else begin
      bus_q           <= SGB_IDLE;
      avs_waitrequest <= 1'b1;
    end
  end

  // Read mux; unmapped addresses read as zero
  always_comb begin
    rd_d = 32'h0000_0000;
    if (avs_address == `SGB_OFF_CTRL) begin
      rd_d[`SGB_CTRL_BANK]                        = bank_q;
      rd_d[`SGB_CTRL_MODE_HI:`SGB_CTRL_MODE_LO]   = mode_q;
      rd_d[`SGB_CTRL_GSEL_EN]                     = gsel_en_q;
      rd_d[`SGB_CTRL_TUNE_REQ]                    = tune_req_q;
    end else if (avs_address == `SGB_OFF_BIAS) begin
      rd_d = {{24{bias_q[7]}}, bias_q};
    end else if (avs_address == `SGB_OFF_STATUS) begin
      rd_d[`SGB_ST_GRP_HI:`SGB_ST_GRP_LO] = act_group;
      rd_d[`SGB_ST_TUNE_ON]               = online_tune_en;
      rd_d[`SGB_ST_SERVO]                 = servo_q;
    end else if (gain_hit) begin
      rd_d[15:0] = mem_q[gain_idx];
    end
  end

  // Read data latched with the acknowledge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if ((bus_q == SGB_IDLE) && avs_read) begin
      avs_readdata <= rd_d;
    end
  end

  // Control word: bank digit, mode digit, select enable, tune request
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bank_q     <= 1'b0;
      mode_q     <= 4'h0;
      gsel_en_q  <= 1'b0;
      tune_req_q <= 1'b0;
    end else if (wr_ok && (avs_address == `SGB_OFF_CTRL)) begin
      if (avs_byteenable[0]) begin
        bank_q <= avs_writedata[`SGB_CTRL_BANK];
        mode_q <= avs_writedata[`SGB_CTRL_MODE_HI:`SGB_CTRL_MODE_LO];
      end
      if (avs_byteenable[1]) begin
        gsel_en_q  <= avs_writedata[`SGB_CTRL_GSEL_EN];
        tune_req_q <= avs_writedata[`SGB_CTRL_TUNE_REQ];
      end
    end
  end

  // Bias clamped to the legal percent range on write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bias_q <= `SGB_BIAS_RST;
    end else if (wr_ok && (avs_address == `SGB_OFF_BIAS) && avs_byteenable[0]) begin
      if (wbias > `SGB_BIAS_MAX) begin
        bias_q <= `SGB_BIAS_MAX;
      end else if (wbias < `SGB_BIAS_MIN) begin
        bias_q <= `SGB_BIAS_MIN;
      end else begin
        bias_q <= wbias;
      end
    end
  end

  // Gain store, one entry per group and value; tuner beats store, store beats bus
  genvar e;
  generate
    for (e = 0; e < `SGB_NENT; e++) begin : g_ent
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          mem_q[e] <= `SGB_GAIN_RST;
        end else if (tune_valid && (e < `SGB_NVAL)) begin
          case (e)
            0: mem_q[e] <= tune_spd_kp;
            1: mem_q[e] <= tune_spd_ki;
            2: mem_q[e] <= tune_pos_kp;
            3: mem_q[e] <= tune_trq_flt;
            default: mem_q[e] <= tune_spd_flt;
          endcase
        end else if (store_d && (e >= `SGB_NVAL) && (e < 2 * `SGB_NVAL)) begin
          mem_q[e] <= mem_q[e - `SGB_NVAL];
        end else if (wr_ok && gain_hit && (gain_idx == e)) begin
          mem_q[e] <= merge16(mem_q[e], avs_writedata, avs_byteenable);
        end
      end
    end
  endgenerate

  // All five active values and the group index move on the same edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      act_group   <= 2'h0;
      act_spd_kp  <= `SGB_GAIN_RST;
      act_spd_ki  <= `SGB_GAIN_RST;
      act_pos_kp  <= `SGB_GAIN_RST;
      act_trq_flt <= `SGB_GAIN_RST;
      act_spd_flt <= `SGB_GAIN_RST;
    end else begin
      act_group   <= sel_d;
      act_spd_kp  <= mem_q[sel_d * 5 + 0];
      act_spd_ki  <= mem_q[sel_d * 5 + 1];
      act_pos_kp  <= mem_q[sel_d * 5 + 2];
      act_trq_flt <= mem_q[sel_d * 5 + 3];
      act_spd_flt <= mem_q[sel_d * 5 + 4];
    end
  end

  // Tuning is held off while the select input is in use
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      online_tune_en   <= 1'b0;
      gain_switch_mode <= 4'h0;
    end else begin
      online_tune_en   <= tune_req_q && !gsel_en_q;
      gain_switch_mode <= mode_q;
    end
  end

  // Bias issued once on the rising edge of servo-on
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      servo_q          <= 1'b0;
      torque_start     <= `SGB_BIAS_RST;
      torque_start_vld <= 1'b0;
    end else begin
      servo_q          <= servo_on;
      torque_start_vld <= servo_on && !servo_q && (bias_q != 0);
      if (servo_on && !servo_q) begin
        torque_start <= bias_q;
      end
    end
  end

  // Checks
  sequence s_req;
    (bus_q == SGB_IDLE) && (avs_read || avs_write);
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  property p_bus_ack;
    @(posedge clk) disable iff (!rst_n) s_req |=> s_ack;
  endproperty
  a_bus_ack: assert property (p_bus_ack) else $error("bus answer not one cycle");

  property p_bias_start;
    @(posedge clk) disable iff (!rst_n)
      (servo_on && !servo_q && bias_q != 0) |=> torque_start_vld && torque_start == $past(bias_q);
  endproperty
  a_bias_start: assert property (p_bias_start) else $error("bias not applied");

  property p_bias_zero;
    @(posedge clk) disable iff (!rst_n) (bias_q == 0) |=> !torque_start_vld;
  endproperty
  a_bias_zero: assert property (p_bias_zero) else $error("zero bias pulsed");

  property p_group;
    @(posedge clk) disable iff (!rst_n)
      1'b1 |=> act_group == {$past(bank_q), $past(gsel_en_q && gain_group_sel)};
  endproperty
  a_group: assert property (p_group) else $error("wrong group chosen");

  property p_tune_off;
    @(posedge clk) disable iff (!rst_n) gsel_en_q ##1 gsel_en_q |-> !online_tune_en;
  endproperty
  a_tune_off: assert property (p_tune_off) else $error("tuning on with select");

  property p_atomic;
    @(posedge clk) disable iff (!rst_n)
      $changed(act_group) |-> act_spd_kp == $past(mem_q[sel_d * 5])
        && act_spd_flt == $past(mem_q[sel_d * 5 + 4]);
  endproperty
  a_atomic: assert property (p_atomic) else $error("mixed gain set");

  property p_store;
    @(posedge clk) disable iff (!rst_n)
      (store_d && !tune_valid) |=> mem_q[5] == $past(mem_q[0]) && mem_q[9] == $past(mem_q[4]);
  endproperty
  a_store: assert property (p_store) else $error("store copy wrong");

  property p_tune_g1;
    @(posedge clk) disable iff (!rst_n)
      (tune_valid && !wr_ok) |=> mem_q[0] == $past(tune_spd_kp) && $stable(mem_q[10])
        && $stable(mem_q[15]);
  endproperty
  a_tune_g1: assert property (p_tune_g1) else $error("tuning touched other group");

  property p_bank;
    @(posedge clk) disable iff (!rst_n) !bank_q ##1 !bank_q |-> !act_group[1];
  endproperty
  a_bank: assert property (p_bank) else $error("bank zero left");
endmodule
`default_nettype wire

/* dv/sgb_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module sgb_host_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic move_phase,
  output var  logic gain_group_sel
);
  // Select pin follows the movement condition, registered like a PLC output
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gain_group_sel <= 1'b0;
    end else begin
      gain_group_sel <= move_phase;
    end
  end
endmodule
`default_nettype wire

/* dv/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sgb_defines.svh"
module tb_top;
  import sgb_pkg::*;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  avs_address = 8'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        move_phase = 1'b0;
  logic        gain_group_sel;
  logic        servo_on = 1'b0;
  logic        tune_valid = 1'b0;
  sgb_gain_t   tune_v [5] = '{default: 16'h0000};
  sgb_gain_t   act_v [5];
  sgb_grp_t    act_group;
  sgb_mode_t   gain_switch_mode;
  logic        online_tune_en;
  sgb_bias_t   torque_start;
  logic        torque_start_vld;
  int          n_errors = 0;
  int          cmp_count = 0;

  // Free running 100 MHz clock
  always #5 clk = ~clk;

  sgb_host_model i_sgb_host_model (.clk(clk), .rst_n(resetn), .move_phase(move_phase),
    .gain_group_sel(gain_group_sel));

  sgb_gain_bank i_sgb_gain_bank (.clk(clk), .resetn(resetn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .gain_group_sel(gain_group_sel), .servo_on(servo_on), .tune_valid(tune_valid),
    .tune_spd_kp(tune_v[0]), .tune_spd_ki(tune_v[1]), .tune_pos_kp(tune_v[2]),
    .tune_trq_flt(tune_v[3]), .tune_spd_flt(tune_v[4]), .act_spd_kp(act_v[0]),
    .act_spd_ki(act_v[1]), .act_pos_kp(act_v[2]), .act_trq_flt(act_v[3]),
    .act_spd_flt(act_v[4]), .act_group(act_group), .gain_switch_mode(gain_switch_mode),
    .online_tune_en(online_tune_en), .torque_start(torque_start),
    .torque_start_vld(torque_start_vld));

  task automatic summarize();
    $display("mismatches %0d, compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  // One Avalon transfer; held until the rising edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    // No own limit: only the watchdog ends a wait that never answers
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask

  // Check all five active values of one group, sampled together
  task automatic chk_group(input int g);
    repeat (4) @(negedge clk);
    chk(act_group, g[1:0]);
    for (int k = 0; k < 5; k++) chk(act_v[k], 16'h1000 + g * 5 + k);
  endtask

  task automatic t_select();
    for (int i = 0; i < 20; i++) wr(`SGB_OFF_GAIN + 4 * i, 32'h1000 + i);
    for (int b = 0; b < 2; b++) begin
      for (int s = 0; s < 2; s++) begin
        @(posedge clk);
        move_phase <= s[0];
        wr(`SGB_OFF_CTRL, 32'h100 | b);
        chk_group(b * 2 + s);
      end
    end
    // Select function off: first group of the bank even with the pin high
    wr(`SGB_OFF_CTRL, 32'h1);
    chk_group(2);
  endtask

  task automatic t_store();
    wr(`SGB_OFF_CMD, 32'h1);
    for (int k = 0; k < 5; k++) rd(`SGB_OFF_GAIN + 4 * (5 + k), 32'h1000 + k);
    rd(`SGB_OFF_CMD, 32'h0);
  endtask

  task automatic t_tune();
    @(posedge clk);
    for (int k = 0; k < 5; k++) tune_v[k] <= 16'hA000 + k;
    tune_valid <= 1'b1;
    @(posedge clk);
    tune_valid <= 1'b0;
    for (int k = 0; k < 5; k++) rd(`SGB_OFF_GAIN + 4 * k, 32'hA000 + k);
    rd(`SGB_OFF_GAIN + 4 * 5, 32'h1000);
    rd(`SGB_OFF_GAIN + 4 * 10, 32'h100A);
    rd(`SGB_OFF_GAIN + 4 * 19, 32'h1013);
  endtask

  task automatic t_ctrl();
    wr(`SGB_OFF_CTRL, 32'h2A0);
    repeat (3) @(negedge clk);
    chk(online_tune_en, 1'b1);
    chk(gain_switch_mode, 4'hA);
    rd(`SGB_OFF_CTRL, 32'h2A0);
    rd(`SGB_OFF_STATUS, 32'h10);
    wr(`SGB_OFF_CTRL, 32'h350);
    repeat (3) @(negedge clk);
    chk(online_tune_en, 1'b0);
    chk(gain_switch_mode, 4'h5);
    // Pin still high from the select scenario, so the second group of bank zero
    rd(`SGB_OFF_STATUS, 32'h01);
  endtask

  // Servo-on rise; count start pulses over a short span
  task automatic servo(input sgb_bias_t exp, input int npulse);
    int c = 0;
    @(posedge clk);
    servo_on <= 1'b1;
    repeat (5) begin
      @(negedge clk);
      if (torque_start_vld === 1'b1) begin
        c++;
        chk(torque_start, exp);
      end
    end
    chk(c, npulse);
    @(posedge clk);
    servo_on <= 1'b0;
  endtask

  task automatic t_bias();
    rd(`SGB_OFF_BIAS, 32'h0);
    wr(`SGB_OFF_BIAS, 32'h7F);
    rd(`SGB_OFF_BIAS, 32'h64);
    wr(`SGB_OFF_BIAS, 32'h80);
    rd(`SGB_OFF_BIAS, 32'hFFFFFF9C);
    servo(8'h9C, 1);
    wr(`SGB_OFF_BIAS, 32'h0);
    servo(8'h00, 0);
    rd(8'h20, 32'h0);
  endtask

  // Main sequence, reset held two cycles, first request after four edges
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    chk(act_group, 2'h0);
    t_bias();
    t_select();
    t_store();
    t_tune();
    t_ctrl();
    summarize();
  end

  // Hang guard, well beyond the few hundred cycles needed
  initial begin
    #300us;
    n_errors++;
    summarize();
  end
endmodule
`default_nettype wire
